// >>> ac_source_setting_status_logic.sv
`timescale 1ns/10ps
`default_nettype none

// Function
// [R01] Frequency 45..500 Hz, reset 60, readable
// [R02] Amplitude 0..300 V, reset 0, readable
// [R03] Applied amplitude bounded by range and limit
// [R04] External mode takes amplitude from reference input
// [R05] Limit 0..300, reset 300, clamps amplitude
// [R06] Range only 150/300, reset 150, clamps
// [R07] Explicit range write clears auto range
// [R08] Auto range picks 300 above 150 V
// [R09] Preset: rise filters set, others cleared
// [R10] Operation event clears on read or clear
// [R11] Operation mask gates operation summary
// [R12] Questionable flag bits 0..7, upper bits zero
// [R13] Questionable event latches, clears on read/clear
// [R14] Questionable condition is live, read-only
// [R15] Questionable mask gates questionable summary
// [R16] Fall/rise filters pass 1-0/0-1 changes
// [R17] Errors queue first in first out
// [R18] Overflow replaces newest entry with -350
// [R19] Empty queue reads as code 0
// [R20] Go-local command enables front panel
// [R21] Remote blocks panel except local key
// [R22] Lockout blocks panel and local key
// [R23] Power-on: rise filters set, rest cleared
// [R24] Summary is OR of event AND mask
module ac_source_setting_status_logic (
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic ce_i,
  input wire ac_source_pkg::cmd_req_type cmd_i,
  output ac_source_pkg::cmd_resp_type resp_o,
  input wire logic err_push_i,
  input wire ac_source_pkg::word_type err_code_i,
  input wire logic [ac_source_pkg::QUESTIONABLE_SUMMARY_FLAG_W-1:0] questionable_summary_flags_i,
  input wire ac_source_pkg::word_type oper_cond_i,
  input wire ac_source_pkg::word_type ext_volt_ref_i,
  input wire logic local_key_i,
  output ac_source_pkg::drive_type drive_o,
  output ac_source_pkg::panel_type panel_o,
  output logic questionable_summary_o,
  output logic operation_summary_o,
  output logic error_pending_o
);
  import ac_source_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    word_type freq;
    word_type ampl;
    word_type limit;
    logic range_high;
    logic auto_range;
    logic ext_mode;
    ctl_state_type ctl;
    logic [QUESTIONABLE_SUMMARY_FLAG_W-1:0] q_sync1;
    logic [QUESTIONABLE_SUMMARY_FLAG_W-1:0] q_sync2;
    logic [QUESTIONABLE_SUMMARY_FLAG_W-1:0] q_prev;
    word_type q_event;
    word_type q_mask;
    word_type q_fall;
    word_type q_rise;
    word_type o_sync1;
    word_type o_sync2;
    word_type o_prev;
    word_type o_event;
    word_type o_mask;
    word_type o_fall;
    word_type o_rise;
    word_type ref_sync1;
    word_type ref_sync2;
    logic key_sync1;
    logic key_sync2;
    logic key_prev;
    logic [ERR_DEPTH-1:0][15:0] err_mem;
    logic [ERR_PTR_W-1:0] err_head;
    logic [ERR_CNT_W-1:0] err_cnt;
    cmd_resp_type resp;
    drive_type drive;
  } state_type;

  state_type r;
  state_type next_r;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic in_span(input word_type v, input word_type lo, input word_type hi);
    in_span = (v >= lo) && (v <= hi);
  endfunction

  function automatic word_type min_word(input word_type a, input word_type b);
    min_word = (a < b) ? a : b;
  endfunction

  function automatic logic [ERR_PTR_W-1:0] err_slot(input logic [ERR_PTR_W-1:0] head,
                                                    input logic [ERR_CNT_W-1:0] off);
    err_slot = ERR_PTR_W'(head + off[ERR_PTR_W-1:0]);
  endfunction

  function automatic word_type edge_hits(input word_type prev, input word_type now,
                                         input word_type rise, input word_type fall);
    edge_hits = (~prev & now & rise) | (prev & ~now & fall);
  endfunction

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic acc;
  word_type q_cond;
  word_type q_prev_w;
  word_type o_cond;
  logic clear_status;
  logic eff_high;
  word_type demand;
  word_type range_cap;

  assign acc = cmd_i.valid;
  assign q_cond = {{(16-QUESTIONABLE_SUMMARY_FLAG_W){1'b0}}, r.q_sync2}; // [R12] [R14]
  assign q_prev_w = {{(16-QUESTIONABLE_SUMMARY_FLAG_W){1'b0}}, r.q_prev};
  assign o_cond = r.o_sync2 & OPER_DEFINED;
  assign clear_status = acc && (cmd_i.code == CMD_CLEAR_STATUS);

  always_comb
  begin
    next_r = r;
    eff_high = 1'b0;
    demand = ZERO_WORD;
    range_cap = ZERO_WORD;
    next_r.resp.valid = 1'b0;

    next_r.q_sync1 = questionable_summary_flags_i;
    next_r.q_sync2 = r.q_sync1;
    next_r.q_prev = r.q_sync2;
    next_r.o_sync1 = oper_cond_i;
    next_r.o_sync2 = r.o_sync1;
    next_r.o_prev = o_cond;
    next_r.ref_sync1 = ext_volt_ref_i;
    next_r.ref_sync2 = r.ref_sync1;
    next_r.key_sync1 = local_key_i;
    next_r.key_sync2 = r.key_sync1;
    next_r.key_prev = r.key_sync2;

    // Events: a new edge in the clearing cycle still sets its bit
    if (clear_status || (acc && cmd_i.code == CMD_QUESTIONABLE_SUMMARY_EV_RD))
    begin
      next_r.q_event = ZERO_WORD; // [R13]
    end
    next_r.q_event = next_r.q_event | edge_hits(q_prev_w, q_cond, r.q_rise, r.q_fall); // [R13] [R16]
    if (clear_status || (acc && cmd_i.code == CMD_OPER_EV_RD))
    begin
      next_r.o_event = ZERO_WORD; // [R10]
    end
    next_r.o_event = next_r.o_event | edge_hits(r.o_prev, o_cond, r.o_rise, r.o_fall);

    // Error queue: pop, then clear, then push
    if (acc && cmd_i.code == CMD_ERR_RD && r.err_cnt != '0)
    begin
      next_r.err_head = r.err_head + ERR_PTR_ONE; // [R17]
      next_r.err_cnt = r.err_cnt - ERR_CNT_ONE;
    end
    if (clear_status)
    begin
      next_r.err_cnt = '0;
    end
    if (err_push_i)
    begin
      if (next_r.err_cnt == ERR_CNT_FULL)
      begin
        next_r.err_mem[err_slot(next_r.err_head, next_r.err_cnt - ERR_CNT_ONE)] = ERR_OVERFLOW; // [R18]
      end
      else
      begin
        next_r.err_mem[err_slot(next_r.err_head, next_r.err_cnt)] = err_code_i; // [R17]
        next_r.err_cnt = next_r.err_cnt + ERR_CNT_ONE;
      end
    end

    // Local key acts only in remote state
    if (r.ctl == CTL_REMOTE && r.key_sync2 && !r.key_prev)
    begin
      next_r.ctl = CTL_LOCAL; // [R21] [R22]
    end

    if (acc)
    begin
      case (cmd_i.code)
        CMD_FREQ_WR:
        begin
          if (in_span(cmd_i.data, FREQ_MIN, FREQ_MAX))
          begin
            next_r.freq = cmd_i.data; // [R01]
          end
        end
        CMD_VOLT_WR:
        begin
          if (in_span(cmd_i.data, ZERO_WORD, VOLT_MAX))
          begin
            next_r.ampl = cmd_i.data; // [R02]
          end
        end
        CMD_LIM_WR:
        begin
          if (in_span(cmd_i.data, ZERO_WORD, VOLT_MAX))
          begin
            next_r.limit = cmd_i.data; // [R05]
          end
        end
        CMD_RANGE_WR:
        begin
          if (cmd_i.data == RANGE_LOW || cmd_i.data == RANGE_HIGH)
          begin
            next_r.range_high = (cmd_i.data == RANGE_HIGH); // [R06]
            next_r.auto_range = 1'b0; // [R07]
          end
        end
        CMD_AUTO_WR: next_r.auto_range = cmd_i.data[0];
        CMD_EPR_WR: next_r.ext_mode = cmd_i.data[0]; // [R04]
        CMD_STAT_PRESET:
        begin
          next_r.q_rise = QUESTIONABLE_SUMMARY_DEFINED; // [R09]
          next_r.o_rise = OPER_DEFINED;
          next_r.q_fall = ZERO_WORD;
          next_r.o_fall = ZERO_WORD;
          next_r.q_mask = ZERO_WORD;
          next_r.o_mask = ZERO_WORD;
        end
        CMD_OPER_EN_WR: next_r.o_mask = cmd_i.data & MASK_MAX; // [R11]
        CMD_QUESTIONABLE_SUMMARY_EN_WR: next_r.q_mask = cmd_i.data & MASK_MAX; // [R15]
        CMD_QUESTIONABLE_SUMMARY_FALL_WR: next_r.q_fall = cmd_i.data & MASK_MAX; // [R16]
        CMD_QUESTIONABLE_SUMMARY_RISE_WR: next_r.q_rise = cmd_i.data & MASK_MAX; // [R16]
        CMD_GO_LOCAL: next_r.ctl = CTL_LOCAL; // [R20]
        CMD_GO_REMOTE: next_r.ctl = CTL_REMOTE; // [R21]
        CMD_GO_LOCKOUT: next_r.ctl = CTL_LOCKOUT; // [R22]
        CMD_SETTINGS_RST:
        begin
          next_r.freq = FREQ_RST;
          next_r.ampl = VOLT_RST;
          next_r.limit = LIMIT_RST;
          next_r.range_high = 1'b0;
          next_r.auto_range = 1'b0;
          next_r.ext_mode = 1'b0;
        end
        default:
        begin
          next_r.resp.valid = 1'b0;
        end
      endcase

      // Read answers return the value held before this command
      next_r.resp.valid = 1'b1;
      case (cmd_i.code)
        CMD_FREQ_RD: next_r.resp.data = r.freq; // [R01]
        CMD_VOLT_RD: next_r.resp.data = r.ampl; // [R02]
        CMD_LIM_RD: next_r.resp.data = r.limit;
        CMD_EPR_RD: next_r.resp.data = {15'h0000, r.ext_mode};
        CMD_AUTO_RD: next_r.resp.data = {15'h0000, r.auto_range};
        CMD_RANGE_RD: next_r.resp.data = r.drive.range_high ? RANGE_HIGH : RANGE_LOW;
        CMD_OPER_EV_RD: next_r.resp.data = r.o_event; // [R10]
        CMD_OPER_COND_RD: next_r.resp.data = o_cond;
        CMD_OPER_EN_RD: next_r.resp.data = r.o_mask;
        CMD_QUESTIONABLE_SUMMARY_EV_RD: next_r.resp.data = r.q_event; // [R13]
        CMD_QUESTIONABLE_SUMMARY_COND_RD: next_r.resp.data = q_cond; // [R14]
        CMD_QUESTIONABLE_SUMMARY_EN_RD: next_r.resp.data = r.q_mask;
        CMD_QUESTIONABLE_SUMMARY_FALL_RD: next_r.resp.data = r.q_fall;
        CMD_QUESTIONABLE_SUMMARY_RISE_RD: next_r.resp.data = r.q_rise;
        CMD_ERR_RD: next_r.resp.data = (r.err_cnt == '0) ? ERR_NONE : r.err_mem[r.err_head]; // [R19]
        default: next_r.resp.valid = 1'b0;
      endcase
    end

    // Applied output follows the settings of the coming cycle
    eff_high = next_r.auto_range ? (next_r.ampl > RANGE_LOW) : next_r.range_high; // [R08]
    range_cap = eff_high ? RANGE_HIGH : RANGE_LOW; // [R06]
    demand = next_r.ext_mode ? r.ref_sync2 : next_r.ampl; // [R04]
    next_r.drive.freq = next_r.freq;
    next_r.drive.range_high = eff_high;
    next_r.drive.ext_mode = next_r.ext_mode;
    next_r.drive.volt_applied = min_word(min_word(demand, next_r.limit), range_cap); // [R03] [R05]
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      r <= '{freq: FREQ_RST, ampl: VOLT_RST, limit: LIMIT_RST,
             q_rise: QUESTIONABLE_SUMMARY_DEFINED, o_rise: OPER_DEFINED, ctl: CTL_LOCAL, // [R23]
             drive: '{freq: FREQ_RST, volt_applied: VOLT_RST, range_high: 1'b0,
                      ext_mode: 1'b0},
             default: '0};
    end
    else if (ce_i)
    begin
      r <= next_r;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign resp_o = r.resp;
  assign drive_o = r.drive;
  assign panel_o.panel_enable = (r.ctl == CTL_LOCAL); // [R20] [R21] [R22]
  assign panel_o.local_key_enable = (r.ctl == CTL_REMOTE);
  assign panel_o.state = r.ctl;
  assign questionable_summary_o = |(r.q_event & r.q_mask); // [R24] [R15]
  assign operation_summary_o = |(r.o_event & r.o_mask); // [R24] [R11]
  assign error_pending_o = (r.err_cnt != '0);

  // ****************************************************************
  // Checks
  // ****************************************************************
  freq_write_a: assert property ( // [R01]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ce_i && acc && cmd_i.code == CMD_FREQ_WR && !in_span(cmd_i.data, FREQ_MIN, FREQ_MAX)
    |=> r.freq == $past(r.freq))
    else $error("out-of-span frequency was stored");

  limit_clamp_a: assert property ( // [R05]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ce_i |=> drive_o.volt_applied <= r.limit)
    else $error("applied voltage above limit");

  range_clamp_a: assert property ( // [R06]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    !drive_o.range_high |-> drive_o.volt_applied <= RANGE_LOW)
    else $error("applied voltage above low range");

  range_clears_auto_a: assert property ( // [R07]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ce_i && acc && cmd_i.code == CMD_RANGE_WR && cmd_i.data == RANGE_HIGH
    |=> !r.auto_range && r.range_high)
    else $error("range write left auto mode on");

  auto_select_a: assert property ( // [R08]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    r.auto_range |-> drive_o.range_high == (r.ampl > RANGE_LOW))
    else $error("auto range picked wrong range");

  preset_values_a: assert property ( // [R09]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ce_i && acc && cmd_i.code == CMD_STAT_PRESET
    |=> r.q_rise == QUESTIONABLE_SUMMARY_DEFINED && r.q_fall == ZERO_WORD && r.q_mask == ZERO_WORD)
    else $error("status preset values wrong");

  questionable_summary_read_a: assert property ( // [R13]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ce_i && acc && cmd_i.code == CMD_QUESTIONABLE_SUMMARY_EV_RD
    |=> resp_o.valid && resp_o.data == $past(r.q_event))
    else $error("questionable event read returned wrong value");

  empty_error_a: assert property ( // [R19]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    ce_i && acc && cmd_i.code == CMD_ERR_RD && r.err_cnt == '0
    |=> resp_o.valid && resp_o.data == ERR_NONE)
    else $error("empty error queue gave nonzero code");

  lockout_key_a: assert property ( // [R22]
    @(posedge clk_sys_i) disable iff (sys_rst_i)
    r.ctl == CTL_LOCKOUT && !(ce_i && acc) |=> r.ctl == CTL_LOCKOUT)
    else $error("lockout left without a command");

endmodule
`default_nettype wire

// >>> ac_source_pkg.sv
`default_nettype none
package ac_source_pkg;

  // ****************************************************************
  // Widths and setting limits (volts and hertz, unsigned integers)
  // ****************************************************************
  typedef logic [15:0] word_type;

  localparam word_type FREQ_MIN = 16'h002D;
  localparam word_type FREQ_MAX = 16'h01F4;
  localparam word_type FREQ_RST = 16'h003C;
  localparam word_type VOLT_MAX = 16'h012C;
  localparam word_type VOLT_RST = 16'h0000;
  localparam word_type LIMIT_RST = 16'h012C;
  localparam word_type RANGE_LOW = 16'h0096;
  localparam word_type RANGE_HIGH = 16'h012C;
  localparam word_type ZERO_WORD = 16'h0000;

  // ****************************************************************
  // Status structures
  // ****************************************************************
  localparam word_type MASK_MAX = 16'h7FFF;
  localparam word_type QUESTIONABLE_SUMMARY_DEFINED = 16'h00FF;
  localparam word_type OPER_DEFINED = 16'h7FFF;
  localparam int QUESTIONABLE_SUMMARY_FLAG_W = 8;
  localparam int BIT_POWER_FAIL = 0;
  localparam int BIT_OPEN_CIRCUIT = 1;
  localparam int BIT_UNDER_VOLTAGE = 2;
  localparam int BIT_OVER_TEMP = 3;
  localparam int BIT_SHORT_CIRCUIT = 4;
  localparam int BIT_OVER_CURRENT = 5;
  localparam int BIT_OVER_POWER = 6;
  localparam int BIT_FAN_FAIL = 7;

  // ****************************************************************
  // Error queue
  // ****************************************************************
  localparam int ERR_DEPTH = 8;
  localparam int ERR_PTR_W = 3;
  localparam int ERR_CNT_W = 4;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_FULL = 4'h8;
  localparam logic [ERR_CNT_W-1:0] ERR_CNT_ONE = 4'h1;
  localparam logic [ERR_PTR_W-1:0] ERR_PTR_ONE = 3'h1;
  localparam word_type ERR_NONE = 16'h0000;
  localparam word_type ERR_OVERFLOW = 16'hFEA2;

  // ****************************************************************
  // Commands, control states and carriers
  // ****************************************************************
  typedef enum logic [4:0] {
    CMD_FREQ_WR, CMD_FREQ_RD, CMD_VOLT_WR, CMD_VOLT_RD, CMD_EPR_WR, CMD_EPR_RD,
    CMD_LIM_WR, CMD_LIM_RD, CMD_RANGE_WR, CMD_RANGE_RD, CMD_AUTO_WR, CMD_AUTO_RD,
    CMD_STAT_PRESET, CMD_OPER_EV_RD, CMD_OPER_COND_RD, CMD_OPER_EN_WR,
    CMD_OPER_EN_RD, CMD_QUESTIONABLE_SUMMARY_EV_RD, CMD_QUESTIONABLE_SUMMARY_COND_RD, CMD_QUESTIONABLE_SUMMARY_EN_WR,
    CMD_QUESTIONABLE_SUMMARY_EN_RD, CMD_QUESTIONABLE_SUMMARY_FALL_WR, CMD_QUESTIONABLE_SUMMARY_FALL_RD, CMD_QUESTIONABLE_SUMMARY_RISE_WR,
    CMD_QUESTIONABLE_SUMMARY_RISE_RD, CMD_ERR_RD, CMD_GO_LOCAL, CMD_GO_REMOTE, CMD_GO_LOCKOUT,
    CMD_CLEAR_STATUS, CMD_SETTINGS_RST
  } cmd_code_type;

  typedef enum logic [1:0] {
    CTL_LOCAL,
    CTL_REMOTE,
    CTL_LOCKOUT
  } ctl_state_type;

  typedef struct packed {
    logic valid;
    cmd_code_type code;
    word_type data;
  } cmd_req_type;

  typedef struct packed {
    logic valid;
    word_type data;
  } cmd_resp_type;

  typedef struct packed {
    word_type freq;
    word_type volt_applied;
    logic range_high;
    logic ext_mode;
  } drive_type;

  typedef struct packed {
    logic panel_enable;
    logic local_key_enable;
    ctl_state_type state;
  } panel_type;

endpackage
`default_nettype wire

// >>> ac_source_host_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// Remote host issuing one-word commands on the parallel cmd_o port
// ****************************************************************
module ac_source_host_model (
  input wire logic clk_i,
  input wire ac_source_pkg::cmd_resp_type resp_i,
  output ac_source_pkg::cmd_req_type cmd_o
);
  import ac_source_pkg::*;
  initial
  begin
    cmd_o = '0;
  end
  // Single pulse; the data field is scrambled once the command is gone
  task automatic send(input cmd_code_type code, input word_type data, input int idle);
    repeat (idle) @(posedge clk_i);
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b1, code: code, data: data};
    @(posedge clk_i);
    cmd_o <= '{valid: 1'b0, code: code, data: ~data};
    #1;
  endtask
  task automatic query(input cmd_code_type code, output word_type data, output logic seen);
    send(code, 16'h0000, 0);
    seen = resp_i.valid;
    data = resp_i.data;
  endtask
endmodule
`default_nettype wire

// >>> test_ac_source_setting_status_logic.sv
`timescale 1ns/10ps
`default_nettype none
module test_ac_source_setting_status_logic;
  import ac_source_pkg::*;
  logic clk_sys_i;
  logic sys_rst_i;
  logic ce;
  logic err_push;
  word_type err_code;
  logic [QUESTIONABLE_SUMMARY_FLAG_W-1:0] flags;
  word_type oper_cond;
  word_type ext_ref;
  logic key;
  cmd_req_type cmd;
  cmd_resp_type resp;
  drive_type drive;
  panel_type panel;
  logic questionable_summary_sum;
  logic oper_sum;
  logic err_pend;
  int error_cnt;
  int check_count;

  ac_source_setting_status_logic DUT (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .ce_i(ce), .cmd_i(cmd), .resp_o(resp),
    .err_push_i(err_push), .err_code_i(err_code), .questionable_summary_flags_i(flags),
    .oper_cond_i(oper_cond), .ext_volt_ref_i(ext_ref), .local_key_i(key),
    .drive_o(drive), .panel_o(panel), .questionable_summary_o(questionable_summary_sum),
    .operation_summary_o(oper_sum), .error_pending_o(err_pend)
  );
  ac_source_host_model host (.clk_i(clk_sys_i), .resp_i(resp), .cmd_o(cmd));

  // ****************************************************************
  // Shared helpers
  // ****************************************************************
  task automatic chk(input string name, input word_type exp, input word_type got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic rd(input string name, input cmd_code_type code, input word_type exp);
    word_type d;
    logic s;
    host.query(code, d, s);
    chk({name, " valid"}, 16'h0001, {15'h0000, s});
    chk(name, exp, d);
  endtask
  task automatic wr(input cmd_code_type code, input word_type data);
    host.send(code, data, 0);
  endtask
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic pulse_key();
    @(posedge clk_sys_i);
    key <= 1'b1;
    wait_cyc(4);
    @(posedge clk_sys_i);
    key <= 1'b0;
    wait_cyc(4);
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_reset();
    rd("freq", CMD_FREQ_RD, FREQ_RST);
    rd("volt", CMD_VOLT_RD, VOLT_RST);
    rd("limit", CMD_LIM_RD, LIMIT_RST);
    rd("range", CMD_RANGE_RD, RANGE_LOW);
    rd("auto", CMD_AUTO_RD, ZERO_WORD);
    rd("ext", CMD_EPR_RD, ZERO_WORD);
    rd("q rise", CMD_QUESTIONABLE_SUMMARY_RISE_RD, QUESTIONABLE_SUMMARY_DEFINED);
    rd("q fall", CMD_QUESTIONABLE_SUMMARY_FALL_RD, ZERO_WORD);
    rd("q mask", CMD_QUESTIONABLE_SUMMARY_EN_RD, ZERO_WORD);
    rd("q event", CMD_QUESTIONABLE_SUMMARY_EV_RD, ZERO_WORD);
    chk("panel", 16'h0001, {15'h0000, panel.panel_enable});
  endtask
  task automatic test_spans();
    wr(CMD_FREQ_WR, 16'h002C);
    rd("freq low", CMD_FREQ_RD, FREQ_RST);
    wr(CMD_FREQ_WR, 16'h01F5);
    rd("freq high", CMD_FREQ_RD, FREQ_RST);
    wr(CMD_FREQ_WR, FREQ_MIN);
    rd("freq min", CMD_FREQ_RD, FREQ_MIN);
    wr(CMD_FREQ_WR, FREQ_MAX);
    rd("freq max", CMD_FREQ_RD, FREQ_MAX);
    chk("drive freq", FREQ_MAX, drive.freq);
    @(posedge clk_sys_i);
    ce <= 1'b0;
    wr(CMD_FREQ_WR, 16'h0078);
    @(posedge clk_sys_i);
    ce <= 1'b1;
    rd("freq frozen", CMD_FREQ_RD, FREQ_MAX);
    wr(CMD_VOLT_WR, 16'h012D);
    rd("volt over", CMD_VOLT_RD, VOLT_RST);
    wr(CMD_VOLT_WR, VOLT_MAX);
    rd("volt max", CMD_VOLT_RD, VOLT_MAX);
  endtask
  task automatic test_clamp();
    wr(CMD_VOLT_WR, 16'h00C8);
    wait_cyc(1);
    chk("applied r150", RANGE_LOW, drive.volt_applied);
    wr(CMD_RANGE_WR, 16'h00C8);
    rd("range bad", CMD_RANGE_RD, RANGE_LOW);
    wr(CMD_RANGE_WR, RANGE_HIGH);
    wait_cyc(1);
    chk("applied r300", 16'h00C8, drive.volt_applied);
    wr(CMD_LIM_WR, 16'h0082);
    wait_cyc(1);
    chk("applied lim", 16'h0082, drive.volt_applied);
    wr(CMD_LIM_WR, 16'h012D);
    rd("limit kept", CMD_LIM_RD, 16'h0082);
    wr(CMD_LIM_WR, LIMIT_RST);
    wr(CMD_AUTO_WR, 16'h0001);
    wr(CMD_VOLT_WR, 16'h0097);
    wait_cyc(1);
    chk("auto high", 16'h0001, {15'h0000, drive.range_high});
    chk("applied auto", 16'h0097, drive.volt_applied);
    wr(CMD_VOLT_WR, 16'h0096);
    wait_cyc(1);
    chk("auto low", 16'h0000, {15'h0000, drive.range_high});
    rd("range eff", CMD_RANGE_RD, RANGE_LOW);
    wr(CMD_RANGE_WR, RANGE_HIGH);
    rd("auto off", CMD_AUTO_RD, ZERO_WORD);
    @(posedge clk_sys_i);
    ext_ref <= 16'h00FA;
    wr(CMD_EPR_WR, 16'h0001);
    wait_cyc(3);
    chk("ext mode", 16'h0001, {15'h0000, drive.ext_mode});
    chk("ext volt", 16'h00FA, drive.volt_applied);
    wr(CMD_EPR_WR, 16'h0000);
    wait_cyc(1);
    chk("stored volt", 16'h0096, drive.volt_applied);
    wr(CMD_SETTINGS_RST, 16'h0000);
    rd("rst freq", CMD_FREQ_RD, FREQ_RST);
    rd("rst volt", CMD_VOLT_RD, VOLT_RST);
    rd("rst range", CMD_RANGE_RD, RANGE_LOW);
    chk("rst applied", VOLT_RST, drive.volt_applied);
  endtask
  task automatic test_questionable_summary();
    wr(CMD_QUESTIONABLE_SUMMARY_EN_WR, 16'hFFFF);
    rd("q mask 15b", CMD_QUESTIONABLE_SUMMARY_EN_RD, MASK_MAX);
    wr(CMD_QUESTIONABLE_SUMMARY_EN_WR, 16'h0008);
    @(posedge clk_sys_i);
    flags <= 8'h08;
    wait_cyc(4);
    chk("q summary", 16'h0001, {15'h0000, questionable_summary_sum});
    rd("q cond", CMD_QUESTIONABLE_SUMMARY_COND_RD, 16'h0008);
    rd("q cond again", CMD_QUESTIONABLE_SUMMARY_COND_RD, 16'h0008);
    rd("q event", CMD_QUESTIONABLE_SUMMARY_EV_RD, 16'h0008);
    rd("q event clr", CMD_QUESTIONABLE_SUMMARY_EV_RD, ZERO_WORD);
    chk("q summary off", 16'h0000, {15'h0000, questionable_summary_sum});
    wr(CMD_QUESTIONABLE_SUMMARY_RISE_WR, 16'h0000);
    wr(CMD_QUESTIONABLE_SUMMARY_FALL_WR, 16'h0008);
    @(posedge clk_sys_i);
    flags <= 8'h00;
    wait_cyc(4);
    rd("q fall ev", CMD_QUESTIONABLE_SUMMARY_EV_RD, 16'h0008);
    @(posedge clk_sys_i);
    flags <= 8'h08;
    wait_cyc(4);
    rd("q no rise", CMD_QUESTIONABLE_SUMMARY_EV_RD, ZERO_WORD);
    wr(CMD_QUESTIONABLE_SUMMARY_RISE_WR, QUESTIONABLE_SUMMARY_DEFINED);
    @(posedge clk_sys_i);
    flags <= 8'hFF;
    wait_cyc(4);
    rd("q bits", CMD_QUESTIONABLE_SUMMARY_EV_RD, 16'h00F7);
    @(posedge clk_sys_i);
    flags <= 8'h00;
    wait_cyc(4);
    wr(CMD_CLEAR_STATUS, 16'h0000);
    rd("q cleared", CMD_QUESTIONABLE_SUMMARY_EV_RD, ZERO_WORD);
  endtask
  task automatic test_oper();
    wr(CMD_OPER_EN_WR, 16'h0001);
    @(posedge clk_sys_i);
    oper_cond <= 16'h0001;
    wait_cyc(4);
    chk("o summary", 16'h0001, {15'h0000, oper_sum});
    rd("o cond", CMD_OPER_COND_RD, 16'h0001);
    rd("o event", CMD_OPER_EV_RD, 16'h0001);
    rd("o event clr", CMD_OPER_EV_RD, ZERO_WORD);
    chk("o summary off", 16'h0000, {15'h0000, oper_sum});
    @(posedge clk_sys_i);
    oper_cond <= 16'h0003;
    wait_cyc(4);
    wr(CMD_CLEAR_STATUS, 16'h0000);
    rd("o cleared", CMD_OPER_EV_RD, ZERO_WORD);
  endtask
  task automatic test_preset();
    wr(CMD_QUESTIONABLE_SUMMARY_RISE_WR, 16'h0000);
    wr(CMD_QUESTIONABLE_SUMMARY_FALL_WR, 16'h00F0);
    wr(CMD_OPER_EN_WR, 16'h0003);
    wr(CMD_STAT_PRESET, 16'h0000);
    rd("p rise", CMD_QUESTIONABLE_SUMMARY_RISE_RD, QUESTIONABLE_SUMMARY_DEFINED);
    rd("p fall", CMD_QUESTIONABLE_SUMMARY_FALL_RD, ZERO_WORD);
    rd("p q mask", CMD_QUESTIONABLE_SUMMARY_EN_RD, ZERO_WORD);
    rd("p o mask", CMD_OPER_EN_RD, ZERO_WORD);
  endtask
  task automatic test_errors();
    rd("err empty", CMD_ERR_RD, ERR_NONE);
    for (int i = 1; i <= ERR_DEPTH + 1; i++)
    begin
      @(posedge clk_sys_i);
      err_push <= 1'b1;
      err_code <= word_type'(i);
    end
    @(posedge clk_sys_i);
    err_push <= 1'b0;
    wait_cyc(1);
    chk("err pending", 16'h0001, {15'h0000, err_pend});
    for (int i = 1; i < ERR_DEPTH; i++)
    begin
      rd("err fifo", CMD_ERR_RD, word_type'(i));
    end
    rd("err overflow", CMD_ERR_RD, ERR_OVERFLOW);
    rd("err drained", CMD_ERR_RD, ERR_NONE);
    chk("err idle", 16'h0000, {15'h0000, err_pend});
  endtask
  task automatic test_panel();
    wr(CMD_GO_REMOTE, 16'h0000);
    chk("remote", 16'(CTL_REMOTE), {14'h0000, panel.state});
    chk("rem panel", 16'h0000, {15'h0000, panel.panel_enable});
    chk("rem key", 16'h0001, {15'h0000, panel.local_key_enable});
    pulse_key();
    chk("key local", 16'(CTL_LOCAL), {14'h0000, panel.state});
    wr(CMD_GO_LOCKOUT, 16'h0000);
    pulse_key();
    chk("lockout", 16'(CTL_LOCKOUT), {14'h0000, panel.state});
    chk("lock key", 16'h0000, {15'h0000, panel.local_key_enable});
    chk("lock panel", 16'h0000, {15'h0000, panel.panel_enable});
    wr(CMD_GO_LOCAL, 16'h0000);
    chk("go local", 16'(CTL_LOCAL), {14'h0000, panel.state});
    chk("loc panel", 16'h0001, {15'h0000, panel.panel_enable});
  endtask
  task automatic test_rerun();
    wr(CMD_QUESTIONABLE_SUMMARY_EN_WR, 16'h0008);
    wr(CMD_GO_LOCKOUT, 16'h0000);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    wait_cyc(2);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    rd("rr q mask", CMD_QUESTIONABLE_SUMMARY_EN_RD, ZERO_WORD);
    rd("rr q rise", CMD_QUESTIONABLE_SUMMARY_RISE_RD, QUESTIONABLE_SUMMARY_DEFINED);
    chk("rr state", 16'(CTL_LOCAL), {14'h0000, panel.state});
  endtask

  // ****************************************************************
  // Run control
  // ****************************************************************
  task automatic conclude();
    $display("Checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
    begin
      $display("Regression OK");
    end
    else
    begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial
  begin
    clk_sys_i = 1'b0;
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  initial
  begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    $display("Watchdog expired before the tests ended");
    conclude();
  end
  initial
  begin
    error_cnt = 0;
    check_count = 0;
    sys_rst_i = 1'b1;
    ce = 1'b1;
    err_push = 1'b0;
    err_code = 16'h0000;
    flags = 8'h00;
    oper_cond = 16'h0000;
    ext_ref = 16'h0000;
    key = 1'b0;
    repeat (5) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    test_reset();
    test_spans();
    test_clamp();
    test_questionable_summary();
    test_oper();
    test_preset();
    test_errors();
    test_panel();
    test_rerun();
    conclude();
  end
endmodule
`default_nettype wire
